// File: logic/sfc_regs.svh
// Purpose: Constants for the serial flash command front end.
// Assumes: Included by its bare name.
// Notes: Opcodes are compared with bit 3 masked where noted.
`ifndef SFC_REGS_SVH
`define SFC_REGS_SVH
`define SFC_OP_WLATCH_SET 8'h06
`define SFC_OP_WLATCH_CLR 8'h04
`define SFC_OP_STAT_RD 8'h05
`define SFC_OP_STAT_WR 8'h01
`define SFC_OP_READ 8'h03
`define SFC_OP_FAST_READ 8'h0b
`define SFC_OP_PROGRAM 8'h02
`define SFC_OP_SECT_ERASE_A 8'h20
`define SFC_OP_SECT_ERASE_B 8'hd7
`define SFC_OP_BLK_ERASE_A 8'h52
`define SFC_OP_BLK_ERASE_B 8'hd8
`define SFC_OP_CHIP_ERASE_A 8'h60
`define SFC_OP_CHIP_ERASE_B 8'hc7
`define SFC_OP_IDENT_A 8'h9f
`define SFC_OP_IDENT_B 8'hab
`define SFC_OP_DC_MASK 8'hf7
`define SFC_ST_LOCK_EN 7
`define SFC_ST_WLATCH 1
`define SFC_ST_BUSY 0
`define SFC_STATUS_RST 8'h00
`define SFC_FAST_DUMMY_BITS 8
`define SFC_WCYCLE_CYCLES 64
`endif

// File: logic/sfc_pkg.sv
// Purpose: Types for the serial flash command front end.
// Assumes: Nothing.
// Notes: States are one-hot.
package sfc_pkg;
  typedef enum logic [4:0] {
    SFC_IDLE = 5'b00001,
    SFC_OPC = 5'b00010,
    SFC_RUN = 5'b00100,
    SFC_DEAD = 5'b01000,
    SFC_DONE = 5'b10000
  } sfc_state_t;
  typedef enum logic [3:0] {
    SFC_K_NONE, SFC_K_STAT_RD, SFC_K_STAT_WR, SFC_K_READ, SFC_K_FAST,
    SFC_K_PROG, SFC_K_ERASE, SFC_K_IDENT, SFC_K_WSET, SFC_K_WCLR
  } sfc_kind_t;
endpackage

// File: logic/sfc_front_end.sv
// Purpose: Serial command front end of a serial flash, SPI slave mode 0/3.
// Assumes: Link pins are asynchronous and are synchronised to mclk.
// Notes: Array contents are outside; array reads return all ones.
`timescale 1ns/1ps
`include "sfc_regs.svh"
// Operation
// - Serial clock is only an input; the block is always the slave.
// - All bytes shift most significant bit first both ways.
// - First byte after select falls goes to an 8-bit opcode register.
// - Unknown opcode: ignore input, output off until reselect.
// - Deselected: input ignored, output high impedance.
// - Pause pin low while clock low suspends; state is kept.
// - While paused, output off and input ignored.
// - Lock pin low with lock enable one refuses status writes.
// - Lock pin falling during a selected status write aborts it.
// - Lock enable zero makes the lock pin ignored.
// - 06 sets, 04 clears the write latch; bit 3 ignored.
// - 05 reads status, 01 writes status; bit 3 ignored.
// - 03 reads array, 0B fast read with dummy cycles.
// - 02 with bit 3 ignored is the program instruction.
// - 20 or D7 erases one sector.
// - 52 or D8 erases one block.
// - 60 or C7 erases the whole array.
// - 9F or AB return the identification bytes identically.
// - Write latch is clear after reset.
// - Clear-latch instruction works whatever the lock pin level.
// - During a write cycle only status read is obeyed.
// - Status: lock enable b7, protect b6..2, latch b1, busy b0.
// - Busy bit is one during a write cycle, zero when ready.
// - Status write cycle starts when select rises after the byte.
// - Write latch clears when the write cycle completes.
// - Identification shifts 24 bits on falling edges, repeating.
module sfc_front_end #(
  parameter logic [23:0] IDENT_CODE = 24'h123456, // Arbitrary value.
  parameter int WCYCLE_CYCLES = `SFC_WCYCLE_CYCLES
) (
  // System
  input wire logic mclk,
  input wire logic rst_b,
  // Serial link pins
  input wire logic sck,
  input wire logic cs_b,
  input wire logic si,
  input wire logic hold_b,
  input wire logic wp_b,
  output logic so_o,
  output logic so_oe,
  // Observation
  output logic [7:0] status_o,
  output logic write_busy_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] sck_s_q, cs_s_q, si_s_q, hold_s_q, wp_s_q;
  logic sck_p_q, wp_p_q;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sck_s_q <= 2'h0;
      cs_s_q <= 2'h3;
      si_s_q <= 2'h0;
      hold_s_q <= 2'h3;
      wp_s_q <= 2'h3;
      sck_p_q <= 1'h0;
      wp_p_q <= 1'h1;
    end else begin
      sck_s_q <= {sck_s_q[0], sck};
      cs_s_q <= {cs_s_q[0], cs_b};
      si_s_q <= {si_s_q[0], si};
      hold_s_q <= {hold_s_q[0], hold_b};
      wp_s_q <= {wp_s_q[0], wp_b};
      sck_p_q <= sck_s_q[1];
      wp_p_q <= wp_s_q[1];
    end
  end
  logic sck_r, cs_n, sin, wp_n, paused_q, paused_d;
  assign sck_r = sck_s_q[1];
  assign cs_n = cs_s_q[1];
  assign sin = si_s_q[1];
  assign wp_n = wp_s_q[1];
  logic rise, fall, wp_fall;
  assign rise = sck_r && !sck_p_q && !paused_q;
  assign fall = !sck_r && sck_p_q && !paused_q;
  assign wp_fall = wp_p_q && !wp_n;
  always_comb begin
    paused_d = paused_q;
    if (cs_n) begin
      paused_d = 1'b0;
    end else if (!sck_r) begin
      paused_d = !hold_s_q[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic sfc_pkg::sfc_kind_t decode(input logic [7:0] op);
    logic [7:0] m;
    m = op & `SFC_OP_DC_MASK;
    decode = sfc_pkg::SFC_K_NONE;
    if (m == `SFC_OP_WLATCH_SET) decode = sfc_pkg::SFC_K_WSET;
    else if (m == `SFC_OP_WLATCH_CLR) decode = sfc_pkg::SFC_K_WCLR;
    else if (m == `SFC_OP_STAT_RD) decode = sfc_pkg::SFC_K_STAT_RD;
    else if (m == `SFC_OP_STAT_WR) decode = sfc_pkg::SFC_K_STAT_WR;
    else if (m == `SFC_OP_PROGRAM) decode = sfc_pkg::SFC_K_PROG;
    else if (op == `SFC_OP_READ) decode = sfc_pkg::SFC_K_READ;
    else if (op == `SFC_OP_FAST_READ) decode = sfc_pkg::SFC_K_FAST;
    else if (op == `SFC_OP_SECT_ERASE_A || op == `SFC_OP_SECT_ERASE_B ||
             op == `SFC_OP_BLK_ERASE_A || op == `SFC_OP_BLK_ERASE_B ||
             op == `SFC_OP_CHIP_ERASE_A || op == `SFC_OP_CHIP_ERASE_B)
      decode = sfc_pkg::SFC_K_ERASE;
    else if (op == `SFC_OP_IDENT_A || op == `SFC_OP_IDENT_B)
      decode = sfc_pkg::SFC_K_IDENT;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  sfc_pkg::sfc_state_t st_q, st_d;
  sfc_pkg::sfc_kind_t kind_q, kind_d;
  logic [7:0] opc_q, opc_d, out_q, out_d;
  logic [5:0] bits_q, bits_d;
  logic [5:0] prot_q, prot_d;
  logic [5:0] new_q, new_d;
  logic wlatch_q, wlatch_d, busy_q, busy_d, sw_ok_q, sw_ok_d, so_q, so_d;
  logic oe_q, oe_d, pend_q, pend_d;
  logic [31:0] wcnt_q, wcnt_d;
  logic [4:0] idp_q, idp_d;
  logic [7:0] status;
  logic locked;
  assign locked = !wp_n && prot_q[5];
  assign status = {prot_q, wlatch_q, busy_q};

  always_comb begin
    st_d = st_q;
    kind_d = kind_q;
    opc_d = opc_q;
    out_d = out_q;
    bits_d = bits_q;
    prot_d = prot_q;
    new_d = new_q;
    wlatch_d = wlatch_q;
    busy_d = busy_q;
    sw_ok_d = sw_ok_q;
    so_d = so_q;
    oe_d = oe_q;
    pend_d = pend_q;
    wcnt_d = wcnt_q;
    idp_d = idp_q;
    if (busy_q) begin
      if (wcnt_q >= 32'(WCYCLE_CYCLES - 1)) begin
        busy_d = 1'b0;
        wlatch_d = 1'b0;
        if (pend_q) prot_d = new_q;
        pend_d = 1'b0;
        wcnt_d = 32'h0;
      end else begin
        wcnt_d = wcnt_q + 32'h1;
      end
    end
    case (st_q)
      sfc_pkg::SFC_IDLE: begin
        oe_d = 1'b0;
        if (!cs_n) begin
          st_d = sfc_pkg::SFC_OPC;
          bits_d = 6'h0;
        end
      end
      sfc_pkg::SFC_OPC: begin
        if (cs_n) begin
          st_d = sfc_pkg::SFC_IDLE;
        end else if (rise) begin
          opc_d = {opc_q[6:0], sin};
          bits_d = bits_q + 6'h1;
          if (bits_q == 6'h7) begin
            kind_d = decode({opc_q[6:0], sin});
            bits_d = 6'h0;
            sw_ok_d = 1'b1;
            out_d = status;
            idp_d = 5'h0;
            st_d = sfc_pkg::SFC_RUN;
            if (kind_d == sfc_pkg::SFC_K_NONE) begin
              st_d = sfc_pkg::SFC_DEAD;
            end else if (busy_q && kind_d != sfc_pkg::SFC_K_STAT_RD) begin
              st_d = sfc_pkg::SFC_DONE;
            end else if (!wlatch_q && (kind_d == sfc_pkg::SFC_K_STAT_WR ||
                kind_d == sfc_pkg::SFC_K_PROG ||
                kind_d == sfc_pkg::SFC_K_ERASE)) begin
              st_d = sfc_pkg::SFC_DONE;
            end else if (kind_d == sfc_pkg::SFC_K_WSET) begin
              wlatch_d = 1'b1;
              st_d = sfc_pkg::SFC_DONE;
            end else if (kind_d == sfc_pkg::SFC_K_WCLR) begin
              wlatch_d = 1'b0;
              st_d = sfc_pkg::SFC_DONE;
            end
          end
        end
      end
      sfc_pkg::SFC_RUN: begin
        if (cs_n) begin
          st_d = sfc_pkg::SFC_IDLE;
          oe_d = 1'b0;
          if (kind_q == sfc_pkg::SFC_K_STAT_WR && sw_ok_q &&
              bits_q >= 6'h8 && !locked) begin
            busy_d = 1'b1;
            pend_d = 1'b1;
            wcnt_d = 32'h0;
          end else if (kind_q == sfc_pkg::SFC_K_PROG ||
                       kind_q == sfc_pkg::SFC_K_ERASE) begin
            busy_d = 1'b1;
            wcnt_d = 32'h0;
          end
        end else begin
          if (kind_q == sfc_pkg::SFC_K_STAT_WR && wp_fall && prot_q[5])
            sw_ok_d = 1'b0;
          if (rise && kind_q == sfc_pkg::SFC_K_STAT_WR && bits_q < 6'h8) begin
            bits_d = bits_q + 6'h1;
            // Only the six upper bits are kept; the two low bits are unused.
            if (bits_q < 6'h6) new_d = {new_q[4:0], sin};
          end
          if (rise && (kind_q == sfc_pkg::SFC_K_FAST ||
                       kind_q == sfc_pkg::SFC_K_READ) && bits_q < 6'h3f)
            bits_d = bits_q + 6'h1;
          if (fall) begin
            case (kind_q)
              sfc_pkg::SFC_K_STAT_RD: begin
                oe_d = 1'b1;
                so_d = out_q[7];
                out_d = {out_q[6:0], 1'b0};
                bits_d = bits_q + 6'h1;
                if (bits_q[2:0] == 3'h7) out_d = status;
              end
              sfc_pkg::SFC_K_IDENT: begin
                oe_d = 1'b1;
                so_d = IDENT_CODE[5'd23 - idp_q];
                idp_d = (idp_q == 5'd23) ? 5'h0 : idp_q + 5'h1;
              end
              sfc_pkg::SFC_K_READ: begin
                oe_d = bits_q >= 6'd24;
                so_d = 1'b1;
              end
              sfc_pkg::SFC_K_FAST: begin
                oe_d = bits_q >= 6'(24 + `SFC_FAST_DUMMY_BITS);
                so_d = 1'b1;
              end
              default: oe_d = 1'b0;
            endcase
          end
        end
      end
      sfc_pkg::SFC_DEAD, sfc_pkg::SFC_DONE: begin
        oe_d = 1'b0;
        if (cs_n) st_d = sfc_pkg::SFC_IDLE;
      end
      default: st_d = sfc_pkg::SFC_IDLE;
    endcase
    // Partial status bytes never start a cycle.
    if (kind_q == sfc_pkg::SFC_K_STAT_WR && st_q == sfc_pkg::SFC_RUN &&
        bits_q == 6'h8 && rise) bits_d = bits_q;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_q <= sfc_pkg::SFC_IDLE;
      kind_q <= sfc_pkg::SFC_K_NONE;
      opc_q <= 8'h00;
      out_q <= 8'h00;
      bits_q <= 6'h00;
      prot_q <= 6'h00;
      new_q <= 6'h00;
      wlatch_q <= 1'b0;
      busy_q <= 1'b0;
      sw_ok_q <= 1'b0;
      so_q <= 1'b0;
      oe_q <= 1'b0;
      pend_q <= 1'b0;
      wcnt_q <= 32'h0;
      idp_q <= 5'h00;
      paused_q <= 1'b0;
    end else begin
      st_q <= st_d;
      kind_q <= kind_d;
      opc_q <= opc_d;
      out_q <= out_d;
      bits_q <= bits_d;
      prot_q <= prot_d;
      new_q <= new_d;
      wlatch_q <= wlatch_d;
      busy_q <= busy_d;
      sw_ok_q <= sw_ok_d;
      so_q <= so_d;
      oe_q <= oe_d;
      pend_q <= pend_d;
      wcnt_q <= wcnt_d;
      idp_q <= idp_d;
      paused_q <= paused_d;
    end
  end

  assign so_o = so_q;
  assign so_oe = oe_q && !cs_n && !paused_q;
  assign status_o = status;
  assign write_busy_o = busy_q;

  ////////////////////////////////////////////////////////////////////////////
  a_deselect_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
    cs_n |-> !so_oe ##1 !oe_q)
    else $error("output driven while deselected");
  a_pause_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
    paused_q && st_q != sfc_pkg::SFC_IDLE |-> !so_oe ##1 $stable(bits_q))
    else $error("output driven or sequence moved while paused");
  a_dead_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
    st_q == sfc_pkg::SFC_DEAD |-> !so_oe && st_d != sfc_pkg::SFC_RUN)
    else $error("dead opcode resumed");
  a_busy_latch: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(busy_q) |-> !wlatch_q) else $error("latch kept after cycle");
  // Write cycles longer than this span would need a counter instead.
  localparam int BUSY_SPAN = 1000;
  a_busy_bounded: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(status_o[0]) |-> ##[1:BUSY_SPAN] !status_o[0])
    else $error("busy bit never returned to ready");
  a_lock_refuse: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(busy_q) && pend_q |-> !$past(locked))
    else $error("locked status write started");
  a_start_deselect: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(busy_q) |-> $past(cs_n)) else $error("cycle began selected");
  a_no_write_unlatched: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(busy_q) |-> $past(wlatch_q)) else $error("write w/o latch");
endmodule // sfc_front_end

// File: tb/sfc_host_model.sv
// Purpose: SPI master that drives the serial link in mode 0.
// Assumes: Each sck phase lasts four mclk cycles.
// Notes: si is inverted when the device is deselected.
`timescale 1ns/1ps
module sfc_host_model (
  // System
  input wire logic mclk,
  // Serial link
  output logic sck,
  output logic cs_b,
  output logic si,
  output logic hold_b,
  input wire logic so_o,
  input wire logic so_oe
);
  int pause_at = -1;
  logic oe_pause = 1'b0;
  initial begin
    sck = 1'b0;
    cs_b = 1'b1;
    si = 1'b0;
    hold_b = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic sel;
    cs_b <= 1'b0;
    wt(4);
  endtask
  task automatic desel;
    wt(4);
    cs_b <= 1'b1;
    si <= ~si;
    wt(1);
  endtask
  // A pause toggles sck and si so the device has to ignore both.
  task automatic xbyte(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      if (i == pause_at) begin
        wt(4);
        hold_b <= 1'b0;
        repeat (4) begin
          wt(4);
          sck <= ~sck;
          si <= ~si;
        end
        wt(4);
        oe_pause = so_oe;
        hold_b <= 1'b1;
        wt(4);
      end
      si <= d[i];
      wt(4);
      sck <= 1'b1;
      wt(4);
      // An undriven line has no pull, so it reads as the inverse here.
      r[i] = so_oe ? so_o : ~so_o;
      sck <= 1'b0;
    end
  endtask
endmodule // sfc_host_model

// File: tb/sfc_front_end_bench.sv
// Purpose: Self-checking bench for the serial flash command front end.
// Assumes: Write cycles are shortened to WC mclk cycles.
// Notes: The status byte is modelled in st.
`timescale 1ns/1ps
module sfc_front_end_bench;
  localparam int WC = 16;
  localparam logic [23:0] ID = 24'h5a3c96; // Arbitrary value.
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic wp_b = 1'b1;
  logic sck, cs_b, si, hold_b, so_o, so_oe, write_busy_o;
  logic [7:0] status_o;
  logic [7:0] rx [$];
  int errors = 0;
  int tests_run = 0;
  int st = 0;
  int oe_seen = 0;
  always #50 mclk = ~mclk;
  always @(posedge mclk) if (so_oe === 1'b1) oe_seen++;
  sfc_host_model host (.mclk(mclk), .sck(sck), .cs_b(cs_b), .si(si),
    .hold_b(hold_b), .so_o(so_o), .so_oe(so_oe));
  sfc_front_end #(.IDENT_CODE(ID), .WCYCLE_CYCLES(WC)) dut (
    .mclk(mclk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b), .si(si),
    .hold_b(hold_b), .wp_b(wp_b), .so_o(so_o), .so_oe(so_oe),
    .status_o(status_o), .write_busy_o(write_busy_o));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] e, g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Mode 1 pulses the lock pin low before deselect; mode 2 drops it once
  // the write cycle is under way.
  task automatic frame(input logic [7:0] q [$], input bit bz,
                       input int drop);
    logic [7:0] r;
    int n;
    rx.delete();
    host.sel();
    foreach (q[i]) begin
      host.xbyte(q[i], r);
      rx.push_back(r);
    end
    if (drop == 1) begin
      wp_b <= 1'b0;
      repeat (4) @(posedge mclk);
      wp_b <= 1'b1;
    end
    host.desel();
    n = 0;
    repeat (40) begin
      @(posedge mclk);
      if (write_busy_o === 1'b1) n++;
      if (drop == 2 && n == 2) wp_b <= 1'b0;
    end
    chk("busy cycles", bz ? WC : 0, n);
  endtask
  task automatic chk_st;
    frame({8'h05, 8'h00, 8'h00}, 1'b0, 0);
    chk("status byte", st, rx[1]);
    chk("status repeat", st, rx[2]);
    chk("status port", st, status_o);
  endtask
  initial begin
    logic [7:0] d;
    logic [7:0] wl [4] = '{8'h06, 8'h04, 8'h0e, 8'h0c};
    logic [7:0] idc [2] = '{8'h9f, 8'hab};
    logic [7:0] ops [8] = '{8'h02, 8'h0a, 8'h20, 8'hd7, 8'h52, 8'hd8,
                            8'h60, 8'hc7};
    int nb [8] = '{4, 4, 3, 3, 3, 3, 0, 0};
    logic [7:0] q [$];
    d = 8'($urandom(32'hcfc8));
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("reset status", 8'h00, status_o);
    chk_st();
    foreach (wl[i]) begin
      frame({wl[i]}, 1'b0, 0);
      st[1] = wl[i][1];
      chk_st();
    end
    frame({8'h01, d}, 1'b0, 0);
    chk_st();
    $display("test latch done");
    wp_b <= 1'b0;
    d = 8'($urandom) | 8'h80;
    frame({8'h06}, 1'b0, 0);
    frame({8'h01, d}, 1'b1, 0);
    st = {d[7:2], 2'b00};
    chk_st();
    frame({8'h06}, 1'b0, 0);
    frame({8'h01, 8'h00}, 1'b0, 0);
    st[1] = 1'b1;
    chk_st();
    frame({8'h04}, 1'b0, 0);
    st[1] = 1'b0;
    chk_st();
    wp_b <= 1'b1;
    frame({8'h06}, 1'b0, 0);
    frame({8'h01, 8'h00}, 1'b0, 1);
    st[1] = 1'b1;
    chk_st();
    wp_b <= 1'b1;
    frame({8'h01, 8'h00}, 1'b1, 2);
    st = 0;
    chk_st();
    wp_b <= 1'b1;
    $display("test lock done");
    foreach (idc[i]) begin
      frame({idc[i], 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 1'b0, 0);
      for (int k = 0; k < 6; k++)
        chk("ident byte", 8'(ID >> (16 - 8 * (k % 3))), rx[k + 1]);
    end
    $display("test ident done");
    foreach (ops[i]) begin
      q = {ops[i]};
      repeat (nb[i]) q.push_back(8'($urandom));
      frame({8'h06}, 1'b0, 0);
      frame(q, 1'b1, 0);
      frame({8'h04}, 1'b0, 0);
    end
    frame({8'h20, 8'h00, 8'h00, 8'h00}, 1'b0, 0);
    frame({8'h03, 8'h01, 8'h02, 8'h03, 8'h00}, 1'b0, 0);
    chk("array read", 8'hff, rx[4]);
    chk("array gap", 8'h00, rx[3]);
    frame({8'h0b, 8'h01, 8'h02, 8'h03, 8'h00, 8'h00}, 1'b0, 0);
    chk("fast read", 8'hff, rx[5]);
    chk("fast dummy", 8'h00, rx[4]);
    $display("test array done");
    oe_seen = 0;
    frame({8'hff, 8'h05, 8'h00}, 1'b0, 0);
    chk("bad opcode drive", 0, oe_seen);
    host.pause_at = 3;
    frame({8'h05, 8'h00}, 1'b0, 0);
    chk("paused status", st, rx[1]);
    chk("paused drive", 1'b0, host.oe_pause);
    host.pause_at = -1;
    chk_st();
    $display("test pause done");
    wrap_up();
  end
  // About 11300 cycles are expected; the limit leaves headroom.
  initial begin
    repeat (90000) @(posedge mclk);
    errors++;
    wrap_up();
  end
endmodule // sfc_front_end_bench
